//--- src/atl_config_regs.sv
/*
  Timing, clamp and LED configuration registers of an imaging front end,
  with the output latency pipeline, reset-sample shifter and strobe pulse
  generator that those registers steer.
  Assumes one clock, synchronous inputs and a one-cycle read strobe master.
*/
`timescale 1ns/100ps
`default_nettype none
module atl_config_regs #(
  parameter int ADC_W = 16
) (
  input wire logic core_clk,
  input wire logic rst_n,
  input wire logic [atl_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [atl_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [atl_pkg::DATA_W-1:0] reg_rdata,
  input wire logic adc_mode_2,
  input wire logic [ADC_W-1:0] adc_data_in,
  output logic [ADC_W-1:0] adc_data_out,
  input wire logic sample_strobe_in,
  output logic timing_strobe,
  input wire logic reset_sample_ref,
  output logic reset_sample_out,
  output logic [3:0] clamp_ref_dac,
  output logic [1:0] internal_colour_sel,
  output logic led_current_limit_range,
  output logic [7:0] red_fine_current,
  output logic [7:0] green_fine_current,
  output logic [7:0] blue_fine_current,
  output logic [1:0] red_coarse_range,
  output logic led_reset
);
  import atl_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic edge_en_q, edge_en_d;
  logic [1:0] lat_q, lat_d;
  logic [3:0] clamp_q, clamp_d;
  logic [1:0] adj_q, adj_d;
  logic [1:0] colour_q, colour_d;
  logic [2:0] delay_q, delay_d;
  logic limit_q, limit_d;
  logic [7:0] red_q, red_d, green_q, green_d, blue_q, blue_d;
  logic [1:0] coarse_q, coarse_d;
  logic led_rst_q, led_rst_d;
  logic [7:0] rdata_q, rdata_d;
  logic sw_rst;
  logic timing_q;

  assign sw_rst = reg_wr && (reg_addr == OFS_SW_RESET);

  // next register values from writes and software reset
  always_comb begin
    edge_en_d = edge_en_q;
    lat_d = lat_q;
    clamp_d = clamp_q;
    adj_d = adj_q;
    colour_d = colour_q;
    delay_d = delay_q;
    limit_d = limit_q;
    red_d = red_q;
    green_d = green_q;
    blue_d = blue_q;
    coarse_d = coarse_q;
    led_rst_d = sw_rst;
    if (sw_rst) begin
      edge_en_d = 1'b0;
      lat_d = LAT_RST;
      clamp_d = CLAMP_RST;
      adj_d = ADJ_RST;
      colour_d = COLOUR_RST;
      delay_d = DELAY_RST;
      limit_d = 1'b0;
      red_d = FINE_RST;
      green_d = FINE_RST;
      blue_d = FINE_RST;
      coarse_d = COARSE_RST;
    end else if (reg_wr) begin
      case (reg_addr)
        OFS_CTRL: begin
          edge_en_d = reg_wdata[EDGE_EN_BIT];
        end
        OFS_LATENCY: begin
          lat_d = reg_wdata[LAT_LSB +: 2];
        end
        OFS_CLAMP_TIMING: begin
          clamp_d = reg_wdata[CLAMP_LSB +: 4];
          adj_d = reg_wdata[ADJ_LSB +: 2];
          colour_d = reg_wdata[COLOUR_LSB +: 2];
        end
        OFS_STROBE_LED: begin
          delay_d = reg_wdata[DELAY_LSB +: 3];
          limit_d = reg_wdata[LIMIT_BIT];
        end
        OFS_RED_FINE: red_d = reg_wdata;
        OFS_GREEN_FINE: green_d = reg_wdata;
        OFS_BLUE_FINE: blue_d = reg_wdata;
        OFS_COARSE: begin
          coarse_d = reg_wdata[COARSE_LSB +: 2];
        end
        default: begin
        end
      endcase
    end
  end

  // read data, one cycle after the strobe; unmapped and write-only read zero
  always_comb begin
    rdata_d = 8'h00;
    if (reg_rd) begin
      case (reg_addr)
        OFS_CTRL: rdata_d[EDGE_EN_BIT] = edge_en_q;
        OFS_LATENCY: rdata_d[LAT_LSB +: 2] = lat_q;
        OFS_CLAMP_TIMING: rdata_d = {colour_q, adj_q, clamp_q};
        OFS_STROBE_LED: begin
          rdata_d[DELAY_LSB +: 3] = delay_q;
          rdata_d[LIMIT_BIT] = limit_q;
        end
        OFS_RED_FINE: rdata_d = red_q;
        OFS_GREEN_FINE: rdata_d = green_q;
        OFS_BLUE_FINE: rdata_d = blue_q;
        OFS_COARSE: rdata_d[COARSE_LSB +: 2] = coarse_q;
        OFS_STATUS: rdata_d = {6'h00, adc_mode_2, timing_q};
        default: rdata_d = 8'h00;
      endcase
    end
  end

  // register bank flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      edge_en_q <= 1'b0;
      lat_q <= LAT_RST;
      clamp_q <= CLAMP_RST;
      adj_q <= ADJ_RST;
      colour_q <= COLOUR_RST;
      delay_q <= DELAY_RST;
      limit_q <= 1'b0;
      red_q <= FINE_RST;
      green_q <= FINE_RST;
      blue_q <= FINE_RST;
      coarse_q <= COARSE_RST;
      led_rst_q <= 1'b0;
      rdata_q <= 8'h00;
    end else begin
      edge_en_q <= edge_en_d;
      lat_q <= lat_d;
      clamp_q <= clamp_d;
      adj_q <= adj_d;
      colour_q <= colour_d;
      delay_q <= delay_d;
      limit_q <= limit_d;
      red_q <= red_d;
      green_q <= green_d;
      blue_q <= blue_d;
      coarse_q <= coarse_d;
      led_rst_q <= led_rst_d;
      rdata_q <= rdata_d;
    end
  end

  // ---------------------------------------------------------------
  // output latency pipeline
  // ---------------------------------------------------------------
  logic [ADC_W-1:0] dpipe_q [LAT_PIPE];
  logic [ADC_W-1:0] dpipe_d [LAT_PIPE];
  logic [ADC_W-1:0] dout_q, dout_d;
  logic [3:0] adc_per;
  logic [3:0] lat_cyc;

  // latency in master clock periods: two or three ADC periods, each 2 clocks or 3 in mode 2
  always_comb begin
    adc_per = adc_mode_2 ? MCLK_PER_ADC_M2 : MCLK_PER_ADC;
    case (lat_q)
      LAT_TWO: lat_cyc = 4'(adc_per * 4'h2);
      LAT_THREE: lat_cyc = 4'(adc_per * 4'h3);
      default: lat_cyc = 4'h0;
    endcase
    dpipe_d[0] = adc_data_in;
    for (int i = 1; i < LAT_PIPE; i++) begin
      dpipe_d[i] = dpipe_q[i-1];
    end
    dout_d = (lat_cyc == 4'h0) ? adc_data_in : dpipe_q[lat_cyc - 4'h1];
  end

  // latency pipeline flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < LAT_PIPE; i++) begin
        dpipe_q[i] <= '0;
      end
      dout_q <= '0;
    end else begin
      dpipe_q <= dpipe_d;
      dout_q <= dout_d;
    end
  end

  // ---------------------------------------------------------------
  // reset sampling shifter and strobe pulse generator
  // ---------------------------------------------------------------
  logic [ADJ_PIPE-1:0] apipe_q, apipe_d;
  logic rso_q, rso_d;
  logic prev_q, prev_d;
  logic [STROBE_PIPE-1:0] spipe_q, spipe_d;
  logic timing_d;
  logic edge_seen;

  // code 01 is the nominal two-cycle path; 00 one earlier, 10/11 later
  always_comb begin
    apipe_d = {apipe_q[ADJ_PIPE-2:0], reset_sample_ref};
    rso_d = (adj_q == 2'h0) ? reset_sample_ref : apipe_q[adj_q - 2'h1];
    prev_d = sample_strobe_in;
    edge_seen = sample_strobe_in && !prev_q;
    spipe_d = {spipe_q[STROBE_PIPE-2:0], edge_seen};
    if (edge_en_q) begin
      timing_d = (delay_q == 3'h0) ? edge_seen : spipe_q[delay_q - 3'h1];
    end else begin
      timing_d = sample_strobe_in;
    end
  end

  // timing flops
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      apipe_q <= '0;
      rso_q <= 1'b0;
      prev_q <= 1'b0;
      spipe_q <= '0;
      timing_q <= 1'b0;
    end else begin
      apipe_q <= apipe_d;
      rso_q <= rso_d;
      prev_q <= prev_d;
      spipe_q <= spipe_d;
      timing_q <= timing_d;
    end
  end

  // ---------------------------------------------------------------
  // outputs
  // ---------------------------------------------------------------
  assign reg_rdata = rdata_q;
  assign adc_data_out = dout_q;
  assign timing_strobe = timing_q;
  assign reset_sample_out = rso_q;
  assign clamp_ref_dac = clamp_q;
  assign internal_colour_sel = colour_q;
  assign led_current_limit_range = limit_q;
  assign red_fine_current = red_q;
  assign green_fine_current = green_q;
  assign blue_fine_current = blue_q;
  assign red_coarse_range = coarse_q;
  assign led_reset = led_rst_q;

  // ---------------------------------------------------------------
  // checks
  // ---------------------------------------------------------------
  default clocking cb @(posedge core_clk);
  endclocking
  default disable iff (!rst_n);

  sequence s_lat_three_m2;
    (lat_q == LAT_THREE && adc_mode_2) [*8] ##1 (lat_q == LAT_THREE && adc_mode_2) [*3];
  endsequence
  property p_lat_three_m2;
    s_lat_three_m2 |-> adc_data_out == $past(adc_data_in, 10);
  endproperty
  a_lat_three_m2: assert property (p_lat_three_m2) else $error("latency 11 mode 2 not nine cycles");

  property p_lat_two_norm;
    (lat_q == LAT_TWO && !adc_mode_2) [*6] |-> adc_data_out == $past(adc_data_in, 5);
  endproperty
  a_lat_two_norm: assert property (p_lat_two_norm) else $error("latency 10 not four cycles");

  property p_lat_min;
    (lat_q == LAT_MIN) [*2] |-> adc_data_out == $past(adc_data_in);
  endproperty
  a_lat_min: assert property (p_lat_min) else $error("minimum latency wrong");

  property p_clamp_wr;
    reg_wr && reg_addr == OFS_CLAMP_TIMING |=> clamp_ref_dac == $past(reg_wdata[3:0]);
  endproperty
  a_clamp_wr: assert property (p_clamp_wr) else $error("clamp level not taken");

  property p_adj_nominal;
    reset_sample_ref && adj_q == ADJ_RST ##1 adj_q == ADJ_RST |=> reset_sample_out;
  endproperty
  a_adj_nominal: assert property (p_adj_nominal) else $error("nominal reset sample not two cycles");

  property p_adj_advance;
    reset_sample_ref && adj_q == 2'h0 |=> reset_sample_out;
  endproperty
  a_adj_advance: assert property (p_adj_advance) else $error("advanced reset sample late");

  property p_sw_reset;
    sw_rst |=> led_reset && red_fine_current == FINE_RST && clamp_ref_dac == CLAMP_RST
      && red_coarse_range == COARSE_RST && !led_current_limit_range;
  endproperty
  a_sw_reset: assert property (p_sw_reset) else $error("software reset incomplete");

  sequence s_edge_d3;
    edge_en_q && delay_q == 3'h3 && sample_strobe_in && !prev_q;
  endsequence
  property p_strobe_delay;
    s_edge_d3 ##1 (edge_en_q && delay_q == 3'h3) [*3] |=> timing_strobe;
  endproperty
  a_strobe_delay: assert property (p_strobe_delay) else $error("strobe pulse delay wrong");

  property p_strobe_direct;
    !edge_en_q |=> timing_strobe == $past(sample_strobe_in);
  endproperty
  a_strobe_direct: assert property (p_strobe_direct) else $error("strobe not passed directly");

  property p_lat_field;
    reg_wr && reg_addr == OFS_LATENCY |=> lat_q == $past(reg_wdata[7:6]);
  endproperty
  a_lat_field: assert property (p_lat_field) else $error("latency field not bits 7:6");
endmodule
`default_nettype wire

//--- src/atl_pkg.sv
/*
  Constants shared by the front-end timing and LED configuration slice:
  register offsets, field positions, widths, reset values and pipeline depths.
  Assumes a plain register port with a 4-bit address and 8-bit data.
*/
// Notes on behaviour
// - output data is delayed by the latency code: 00 minimum, 10 two and 11 three ADC clock periods more.
// - one ADC clock period is two master clock periods, or three while mode 2 is selected.
// - the clamp reference DAC follows a four-bit level in bits 3:0 that resets to 0011.
// - the reset sampling instant moves by the adjust field: 00 one period earlier, 10 one later, 11 two later.
// - the internal colour field selects 00 red, 01 green, 10 blue, with 11 reserved.
// - any write to the software reset location returns every cell, the LED drive included, to reset.
// - with edge detection on, the generated pulse follows the detected strobe edge by one period plus the delay field in periods.
// - with edge detection off, the strobe delay field has no effect.
// - bit 6 of the strobe delay register picks one of two LED current limit ranges.
// - red, green and blue each have an eight-bit fine current code that resets to 00100000.
// - the red coarse current range sits in bits 1:0 of the coarse range register and resets to 00.
// - with edge detection on, a pulse derived from the strobe feeds timing control, else the strobe passes directly.
// - the latency field is bits 7:6 of its register and resets to 00.
`default_nettype none
package atl_pkg;
  // -----------------------------------------------------------------
  // register map
  // -----------------------------------------------------------------
  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;
  localparam logic [3:0] OFS_CTRL = 4'h0;
  localparam logic [3:0] OFS_LATENCY = 4'h1;
  localparam logic [3:0] OFS_CLAMP_TIMING = 4'h2;
  localparam logic [3:0] OFS_STROBE_LED = 4'h3;
  localparam logic [3:0] OFS_RED_FINE = 4'h4;
  localparam logic [3:0] OFS_GREEN_FINE = 4'h5;
  localparam logic [3:0] OFS_BLUE_FINE = 4'h6;
  localparam logic [3:0] OFS_COARSE = 4'h7;
  localparam logic [3:0] OFS_SW_RESET = 4'h8;
  localparam logic [3:0] OFS_STATUS = 4'h9;
  // -----------------------------------------------------------------
  // field positions
  // -----------------------------------------------------------------
  localparam int EDGE_EN_BIT = 3;
  localparam int LAT_LSB = 6;
  localparam int CLAMP_LSB = 0;
  localparam int ADJ_LSB = 4;
  localparam int COLOUR_LSB = 6;
  localparam int DELAY_LSB = 0;
  localparam int LIMIT_BIT = 6;
  localparam int COARSE_LSB = 0;
  // -----------------------------------------------------------------
  // reset values
  // -----------------------------------------------------------------
  localparam logic [1:0] LAT_RST = 2'h0;
  localparam logic [3:0] CLAMP_RST = 4'h3;
  localparam logic [1:0] ADJ_RST = 2'h1;
  localparam logic [1:0] COLOUR_RST = 2'h0;
  localparam logic [2:0] DELAY_RST = 3'h0;
  localparam logic [7:0] FINE_RST = 8'h20;
  localparam logic [1:0] COARSE_RST = 2'h0;
  // -----------------------------------------------------------------
  // encodings and timing
  // -----------------------------------------------------------------
  localparam logic [1:0] LAT_MIN = 2'h0;
  localparam logic [1:0] LAT_TWO = 2'h2;
  localparam logic [1:0] LAT_THREE = 2'h3;
  localparam logic [3:0] MCLK_PER_ADC = 4'h2;
  localparam logic [3:0] MCLK_PER_ADC_M2 = 4'h3;
  localparam int LAT_PIPE = 9;
  localparam int STROBE_PIPE = 7;
  localparam int ADJ_PIPE = 3;
  typedef enum logic [1:0] {
    ATL_RED = 2'b00,
    ATL_GREEN = 2'b01,
    ATL_BLUE = 2'b10,
    ATL_RSVD = 2'b11
  } atl_colour_e;
endpackage
`default_nettype wire

//--- verification/tb_top.sv
/*
  Self-checking testbench for the timing and LED configuration slice.
  Assumes the design package is compiled first and that the block answers reads one cycle after the strobe.
*/
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import atl_pkg::*;
  logic core_clk;
  logic rst_n;
  logic [ADDR_W-1:0] reg_addr;
  logic [DATA_W-1:0] reg_wdata;
  logic reg_wr;
  logic reg_rd;
  logic [DATA_W-1:0] reg_rdata;
  logic adc_mode_2;
  logic [15:0] adc_data_in;
  logic [15:0] adc_data_out;
  logic sample_strobe_in;
  logic timing_strobe;
  logic reset_sample_ref;
  logic reset_sample_out;
  logic [3:0] clamp_ref_dac;
  logic [1:0] internal_colour_sel;
  logic led_current_limit_range;
  logic [7:0] red_fine_current;
  logic [7:0] green_fine_current;
  logic [7:0] blue_fine_current;
  logic [1:0] red_coarse_range;
  logic led_reset;
  int failures;
  int n_tests;

  // ---------------------------------------------------------------
  // device under test
  // ---------------------------------------------------------------
  atl_config_regs #(.ADC_W(16)) dut (
    .core_clk(core_clk), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .adc_mode_2(adc_mode_2),
    .adc_data_in(adc_data_in), .adc_data_out(adc_data_out), .sample_strobe_in(sample_strobe_in),
    .timing_strobe(timing_strobe), .reset_sample_ref(reset_sample_ref),
    .reset_sample_out(reset_sample_out), .clamp_ref_dac(clamp_ref_dac),
    .internal_colour_sel(internal_colour_sel), .led_current_limit_range(led_current_limit_range),
    .red_fine_current(red_fine_current), .green_fine_current(green_fine_current),
    .blue_fine_current(blue_fine_current), .red_coarse_range(red_coarse_range), .led_reset(led_reset)
  );

  // ---------------------------------------------------------------
  // clock, verdict and helpers
  // ---------------------------------------------------------------
  // free-running 100 MHz clock
  initial begin
    core_clk = 1'b0;
    forever #5 core_clk = ~core_clk;
  end

  task automatic tally_and_finish();
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  // one compare for every kind of result
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  // read data is looked at only in the cycle after the strobe
  task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1;
    chk({8'h00, reg_rdata}, {8'h00, exp});
  endtask

  // drives a one-cycle stimulus on one path and counts clocks until it shows
  task automatic meas(input int sel, output int d);
    int n;
    d = -1;
    @(posedge core_clk);
    case (sel)
      0: adc_data_in <= 16'hA5C3;
      1: reset_sample_ref <= 1'b1;
      default: sample_strobe_in <= 1'b1;
    endcase
    for (n = 1; n <= 30; n++) begin
      @(posedge core_clk);
      if (n == 1) begin
        adc_data_in <= 16'h0000;
        reset_sample_ref <= 1'b0;
        sample_strobe_in <= 1'b0;
      end
      #1;
      if (d < 0 && ((sel == 0 && adc_data_out === 16'hA5C3) || (sel == 1 && reset_sample_out === 1'b1) ||
          (sel == 2 && timing_strobe === 1'b1))) begin
        d = n;
      end
    end
  endtask

  // ---------------------------------------------------------------
  // scenarios
  // ---------------------------------------------------------------
  task automatic t_reset_values();
    chk({12'h000, clamp_ref_dac}, 16'h0003);
    chk({14'h0000, internal_colour_sel}, 16'h0000);
    chk({red_fine_current, green_fine_current}, 16'h2020);
    chk({8'h00, blue_fine_current}, 16'h0020);
    chk({14'h0000, red_coarse_range}, 16'h0000);
    rd_chk(OFS_LATENCY, 8'h00);
    rd_chk(OFS_CLAMP_TIMING, 8'h13);
    rd_chk(OFS_COARSE, 8'h00);
    rd_chk(4'hF, 8'h00);
  endtask

  task automatic t_latency();
    int d;
    int p;
    int e;
    for (int m = 0; m < 2; m++) begin
      @(posedge core_clk);
      adc_mode_2 <= m[0];
      p = (m == 1) ? 3 : 2;
      for (int c = 0; c < 4; c++) begin
        wr(OFS_LATENCY, 8'(c << 6));
        e = 1 + ((c == 2) ? 2 * p : (c == 3) ? 3 * p : 0);
        meas(0, d);
        chk(16'(d), 16'(e));
      end
    end
    // status shows mode 2 held and no strobe pending
    rd_chk(OFS_STATUS, 8'h02);
  endtask

  // adjust code 01 is the nominal instant, the others shift it
  task automatic t_reset_sample();
    int d;
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CLAMP_TIMING, 8'(8'h03 | (c << 4)));
      meas(1, d);
      chk(16'(d), 16'(c + 1));
    end
  endtask

  task automatic t_strobe();
    int d;
    int dl [3] = '{0, 3, 7};
    wr(OFS_STROBE_LED, 8'h05);
    wr(OFS_CTRL, 8'h00);
    meas(2, d);
    chk(16'(d), 16'h0001);
    wr(OFS_CTRL, 8'h08);
    rd_chk(OFS_CTRL, 8'h08);
    foreach (dl[i]) begin
      wr(OFS_STROBE_LED, 8'(dl[i]));
      meas(2, d);
      chk(16'(d), 16'(1 + dl[i]));
    end
  endtask

  task automatic t_fields();
    for (int c = 0; c < 4; c++) begin
      wr(OFS_CLAMP_TIMING, 8'((c << 6) | 8'h1A));
      chk({12'h000, clamp_ref_dac}, 16'h000A);
      chk({14'h0000, internal_colour_sel}, 16'(c));
    end
    wr(OFS_STROBE_LED, 8'h45);
    chk({15'h0000, led_current_limit_range}, 16'h0001);
    rd_chk(OFS_STROBE_LED, 8'h45);
    wr(OFS_RED_FINE, 8'hC1);
    wr(OFS_GREEN_FINE, 8'h7E);
    wr(OFS_BLUE_FINE, 8'hFF);
    chk({red_fine_current, green_fine_current}, 16'hC17E);
    chk({8'h00, blue_fine_current}, 16'h00FF);
    rd_chk(OFS_GREEN_FINE, 8'h7E);
    wr(OFS_COARSE, 8'h03);
    chk({14'h0000, red_coarse_range}, 16'h0003);
    rd_chk(OFS_COARSE, 8'h03);
  endtask

  // any data written to the reset location returns every cell to its reset value
  task automatic t_soft_reset();
    wr(OFS_LATENCY, 8'hC0);
    wr(OFS_SW_RESET, 8'h5A);
    chk({15'h0000, led_reset}, 16'h0001);
    chk({red_fine_current, blue_fine_current}, 16'h2020);
    chk({12'h000, clamp_ref_dac}, 16'h0003);
    chk({13'h0000, led_current_limit_range, red_coarse_range}, 16'h0000);
    chk({6'h00, internal_colour_sel, green_fine_current}, 16'h0020);
    @(posedge core_clk);
    #1;
    chk({15'h0000, led_reset}, 16'h0000);
    rd_chk(OFS_LATENCY, 8'h00);
    rd_chk(OFS_CLAMP_TIMING, 8'h13);
    rd_chk(OFS_CTRL, 8'h00);
    rd_chk(OFS_SW_RESET, 8'h00);
  endtask

  // ---------------------------------------------------------------
  // main sequence and watchdog
  // ---------------------------------------------------------------
  initial begin
    failures = 0;
    n_tests = 0;
    rst_n = 1'b0;
    reg_addr = '0;
    reg_wdata = '0;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    adc_mode_2 = 1'b0;
    adc_data_in = '0;
    sample_strobe_in = 1'b0;
    reset_sample_ref = 1'b0;
    repeat (5) @(posedge core_clk);
    rst_n <= 1'b1;
    #1;
    t_reset_values();
    wr(OFS_SW_RESET, 8'h00);
    t_latency();
    t_reset_sample();
    t_strobe();
    t_fields();
    t_soft_reset();
    tally_and_finish();
  end

  // cuts a hang short well beyond the expected run length
  initial begin
    repeat (20000) @(posedge core_clk);
    failures++;
    tally_and_finish();
  end
endmodule
`default_nettype wire
